//--- isra_master.sv
// Operation
// - Idle bus leaves SCL and SDA released and high.
// - START is SDA falling while SCL is high.
// - STOP is SDA rising while SCL is high; bus is then free.
// - One bit per SCL pulse; SDA stable through SCL high.
// - Ninth pulse carries acknowledge; receiver holds SDA low through high phase.
// - Master supplies the ninth clock for every byte.
// - Slave acknowledges bytes it receives; master acknowledges each byte it reads except the last, which it NACKs.
// - Master originates transfers and makes SCL; slave never drives SCL.
// - Master alone initiates transfers and sources the serial clock.
// - Seven-bit address then direction bit: 0 write, 1 read.
// - To read, first write the command byte, then read any count.
// - Reload the pointer before reading back just-written registers.
// - Use repeated START between pointer write and read.
`timescale 1ns/100ps
module isra_master
    import isra_pkg::*;
#(
    parameter int QUARTER_CYCLES = SCL_QUARTER_CYCLES,
    parameter int STALL_LIMIT = STALL_LIMIT_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [1:0] ADDR_SELECT,
    input wire logic CMD_VALID,
    input wire logic CMD_READ,
    input wire logic [7:0] CMD_PTR,
    input wire logic [7:0] CMD_COUNT,
    output logic CMD_READY,
    input wire logic WR_VALID,
    input wire logic [7:0] WR_DATA,
    output logic WR_TAKEN,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic DONE,
    output logic NACK,
    output logic ABORT
);
    localparam int SW = $clog2(STALL_LIMIT + 1);
    localparam logic [SW-1:0] STALL_LAST = SW'(STALL_LIMIT - 1);

    isra_bit_if bus ();

    isra_state_t state;
    isra_kind_t kind;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] remain;
    logic [2:0] bitcnt;
    logic [6:0] dev_addr;
    logic is_read;
    logic issued;
    logic pin_low;
    logic [SW-1:0] stall;
    logic want_op;
    isra_op_t cur_op;
    logic cur_bit;

    ////////////////////////////////////////////////////////////////////////////
    isra_bit_engine #(
        .QUARTER_CYCLES(QUARTER_CYCLES)
    ) u_engine (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .bus(bus),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .scl_oe(SCL_OE),
        .sda_oe(SDA_OE)
    );

    // Both lines are open drain: the driven level is always low.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_low <= 1'h0;
        end else begin
            pin_low <= 1'h0;
        end
    end
    assign SCL_OUT = pin_low;
    assign SDA_OUT = pin_low;

    ////////////////////////////////////////////////////////////////////////////
    // Bit operation wanted by the current sequencer state.
    always_comb begin
        want_op = 1'h1;
        cur_op = OP_READ;
        cur_bit = 1'h1;
        case (state)
            ST_START: cur_op = OP_START;
            ST_SEND: begin
                cur_op = OP_WRITE;
                cur_bit = shift[7];
            end
            ST_SACK: cur_op = OP_READ;
            ST_RECV: cur_op = OP_READ;
            ST_MACK: begin
                cur_op = OP_WRITE;
                cur_bit = (remain == 8'h01);
            end
            ST_STOP: cur_op = OP_STOP;
            default: want_op = 1'h0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            issued <= 1'h0;
            bus.valid <= 1'h0;
            bus.op <= OP_STOP;
            bus.wbit <= 1'h1;
        end else begin
            bus.valid <= 1'h0;
            if (bus.done) begin
                issued <= 1'h0;
            end else if (want_op && !issued) begin
                issued <= 1'h1;
                bus.valid <= 1'h1;
                bus.op <= cur_op;
                bus.wbit <= cur_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte sequencer. Every command rewrites the pointer first, so a read
    // never depends on where an earlier write left it.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            kind <= KIND_ADDR_W;
            shift <= 8'h00;
            ptr <= 8'h00;
            remain <= 8'h00;
            bitcnt <= 3'h0;
            dev_addr <= 7'h00;
            is_read <= 1'h0;
            stall <= '0;
            CMD_READY <= 1'h1;
            WR_TAKEN <= 1'h0;
            RD_DATA <= 8'h00;
            RD_VALID <= 1'h0;
            DONE <= 1'h0;
            NACK <= 1'h0;
            ABORT <= 1'h0;
        end else begin
            WR_TAKEN <= 1'h0;
            RD_VALID <= 1'h0;
            DONE <= 1'h0;
            unique case (state)
                ST_IDLE: begin
                    if (CMD_VALID && CMD_READY) begin
                        CMD_READY <= 1'h0;
                        is_read <= CMD_READ;
                        ptr <= CMD_PTR;
                        remain <= CMD_COUNT;
                        dev_addr <= {DEV_ADDR_HIGH, ADDR_SELECT};
                        kind <= KIND_ADDR_W;
                        NACK <= 1'h0;
                        ABORT <= 1'h0;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (bus.done) begin
                        shift <= {dev_addr, (kind == KIND_ADDR_R) ? DIR_READ : DIR_WRITE};
                        bitcnt <= 3'h7;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (bus.done) begin
                        shift <= {shift[6:0], 1'b0};
                        bitcnt <= bitcnt - 3'h1;
                        if (bitcnt == 3'h0) begin
                            state <= ST_SACK;
                        end
                    end
                end
                ST_SACK: begin
                    if (bus.done) begin
                        if (bus.rbit) begin
                            NACK <= 1'h1;
                            state <= ST_STOP;
                        end else begin
                            unique case (kind)
                                KIND_ADDR_W: begin
                                    shift <= ptr;
                                    bitcnt <= 3'h7;
                                    kind <= KIND_PTR;
                                    state <= ST_SEND;
                                end
                                KIND_PTR: begin
                                    if (remain == 8'h00) begin
                                        state <= ST_STOP;
                                    end else if (is_read) begin
                                        kind <= KIND_ADDR_R;
                                        state <= ST_START;
                                    end else begin
                                        state <= ST_WAITD;
                                    end
                                end
                                KIND_WDATA: begin
                                    remain <= remain - 8'h01;
                                    state <= (remain == 8'h01) ? ST_STOP : ST_WAITD;
                                end
                                KIND_ADDR_R: begin
                                    bitcnt <= 3'h7;
                                    state <= ST_RECV;
                                end
                            endcase
                        end
                    end
                end
                ST_WAITD: begin
                    if (WR_VALID) begin
                        shift <= WR_DATA;
                        WR_TAKEN <= 1'h1;
                        kind <= KIND_WDATA;
                        bitcnt <= 3'h7;
                        stall <= '0;
                        state <= ST_SEND;
                    end else if (stall == STALL_LAST) begin
                        // Give up well before the slave's own timeout fires.
                        ABORT <= 1'h1;
                        stall <= '0;
                        state <= ST_STOP;
                    end else begin
                        stall <= stall + {{(SW-1){1'b0}}, 1'b1};
                    end
                end
                ST_RECV: begin
                    if (bus.done) begin
                        shift <= {shift[6:0], bus.rbit};
                        bitcnt <= bitcnt - 3'h1;
                        if (bitcnt == 3'h0) begin
                            state <= ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (bus.done) begin
                        RD_DATA <= shift;
                        RD_VALID <= 1'h1;
                        remain <= remain - 8'h01;
                        bitcnt <= 3'h7;
                        state <= (remain == 8'h01) ? ST_STOP : ST_RECV;
                    end
                end
                ST_STOP: begin
                    if (bus.done) begin
                        CMD_READY <= 1'h1;
                        DONE <= 1'h1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    CMD_READY <= 1'h1;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- isra_pkg.sv
package isra_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Device addressing and register map of the slave outside.
    localparam logic [4:0] DEV_ADDR_HIGH = 5'h13;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic [7:0] REG_DEV_CONFIG = 8'h27;
    localparam int CFG_TIMEOUT_DISABLE_BIT = 7;
    localparam logic [7:0] REG_GROUP_LOW = 8'h3C;
    localparam logic [7:0] REG_GROUP_HIGH = 8'h3D;

    ////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCL_PERIOD_NS = 10000;
    // Least time per quarter of an SCL period, rounded up.
    localparam int SCL_QUARTER_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_TIMEOUT_MS = 31;
    localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    // The host never holds the bus idle mid-transfer for more than half the
    // slave's timeout, so a slow data source cannot trip the slave's reset.
    localparam int STALL_LIMIT_CYCLES = BUS_TIMEOUT_CYCLES / 2;

    ////////////////////////////////////////////////////////////////////////////
    // Bit-level operations and sequencer states.
    typedef enum logic [3:0] {
        OP_START = 4'h1,
        OP_STOP = 4'h2,
        OP_WRITE = 4'h4,
        OP_READ = 4'h8
    } isra_op_t;

    typedef enum logic [3:0] {
        KIND_ADDR_W = 4'h1,
        KIND_PTR = 4'h2,
        KIND_WDATA = 4'h4,
        KIND_ADDR_R = 4'h8
    } isra_kind_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_START = 8'h02,
        ST_SEND = 8'h04,
        ST_SACK = 8'h08,
        ST_WAITD = 8'h10,
        ST_RECV = 8'h20,
        ST_MACK = 8'h40,
        ST_STOP = 8'h80
    } isra_state_t;

endpackage

//--- isra_bit_if.sv
`timescale 1ns/100ps
interface isra_bit_if;
    import isra_pkg::*;
    logic valid;
    isra_op_t op;
    logic wbit;
    logic done;
    logic rbit;

    modport seq (output valid, output op, output wbit, input done, input rbit);
    modport engine (input valid, input op, input wbit, output done, output rbit);
endinterface

//--- isra_bit_engine.sv
`timescale 1ns/100ps
module isra_bit_engine
    import isra_pkg::*;
#(
    parameter int QUARTER_CYCLES = SCL_QUARTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    isra_bit_if.engine bus,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe,
    output logic sda_oe
);
    localparam int CW = $clog2(QUARTER_CYCLES + 1);
    localparam logic [CW-1:0] QC = CW'(QUARTER_CYCLES);

    logic scl_meta;
    logic scl_sync;
    logic sda_meta;
    logic sda_sync;
    logic running;
    isra_op_t op;
    logic wbit;
    logic [1:0] quarter;
    logic [CW-1:0] count;
    logic scl_rel;
    logic sda_rel;
    logic stall;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta <= 1'h1;
            scl_sync <= 1'h1;
            sda_meta <= 1'h1;
            sda_sync <= 1'h1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    // Line levels per quarter; each op ends with SCL low except STOP.
    always_comb begin
        scl_rel = 1'h1;
        sda_rel = 1'h1;
        case (op)
            OP_START: begin
                scl_rel = (quarter == 2'h1) || (quarter == 2'h2);
                sda_rel = (quarter <= 2'h1);
            end
            OP_STOP: begin
                scl_rel = (quarter != 2'h0);
                sda_rel = (quarter >= 2'h2);
            end
            OP_WRITE: begin
                scl_rel = (quarter == 2'h1) || (quarter == 2'h2);
                sda_rel = wbit;
            end
            OP_READ: begin
                scl_rel = (quarter == 2'h1) || (quarter == 2'h2);
                sda_rel = 1'h1;
            end
            default: begin
                scl_rel = 1'h1;
                sda_rel = 1'h1;
            end
        endcase
    end

    // A released SCL that still reads low is being held; wait it out.
    assign stall = scl_rel && !scl_sync;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'h0;
            op <= OP_STOP;
            wbit <= 1'h1;
            quarter <= 2'h3;
            count <= QC;
            bus.done <= 1'h0;
        end else begin
            bus.done <= 1'h0;
            if (!running) begin
                if (bus.valid) begin
                    running <= 1'h1;
                    op <= bus.op;
                    wbit <= bus.wbit;
                    quarter <= 2'h0;
                    count <= QC;
                end
            end else if (!stall) begin
                if (count == {{(CW-1){1'b0}}, 1'b1}) begin
                    count <= QC;
                    if (quarter == 2'h3) begin
                        running <= 1'h0;
                        bus.done <= 1'h1;
                    end else begin
                        quarter <= quarter + 2'h1;
                    end
                end else begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Data is taken at the end of the SCL high phase, where it is stable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rbit <= 1'h1;
        end else if (running && !stall && quarter == 2'h2
                     && count == {{(CW-1){1'b0}}, 1'b1}) begin
            bus.rbit <= sda_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe <= 1'h0;
            sda_oe <= 1'h0;
        end else begin
            scl_oe <= !scl_rel;
            sda_oe <= !sda_rel;
        end
    end
endmodule

//--- isra_slave_model.sv
`timescale 1ns/100ps
module isra_slave_model #(
    parameter logic [1:0] SEL = 2'h2,
    parameter int TIMEOUT_NS = 31000000
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe
);
    // There is no SCL output: this device only ever listens to the clock.
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] sr;
    int cnt;
    int ph;
    logic scl_was = 1'h1;
    logic sda_was = 1'h1;
    logic tick = 1'h0;
    time scl_low_at;
    time sda_low_at;

    initial begin
        sda_oe = 1'h0;
        ptr = 8'h00;
        sr = 8'h00;
        cnt = 0;
        ph = 0;
        for (int k = 0; k < 256; k++) begin
            mem[k] = ~8'(k);
        end
        // Timeout armed, so a frame hung by the host would be dropped here.
        mem[8'h27][7] = 1'h0;
    end

    // Coarse tick that lets the timeout be noticed while both lines sit still.
    always #1000 tick = !tick;

    // Phases: 1 address, 2 command byte, 3 write data, 4 read data.
    task on_scl_fall;
        if (ph != 0 && cnt == 8) begin
            sda_oe = (ph != 4);
            if (ph == 1) begin
                if (sr[7:1] != {5'h13, SEL}) begin
                    ph = 0;
                    sda_oe = 1'h0;
                end else begin
                    ph = sr[0] ? 4 : 2;
                end
            end else if (ph == 2) begin
                ptr = sr;
                ph = 3;
            end else begin
                if (ph == 3 && (ptr == 8'h3C || ptr == 8'h3D)) begin
                    for (int k = 0; k < 4; k++) begin
                        mem[(ptr == 8'h3C ? 2 : 6) + k] = sr;
                    end
                end else if (ph == 3) begin
                    mem[ptr] = sr;
                end
                ptr = ptr + 8'h01;
            end
        end else if (ph != 0 && cnt == 9) begin
            cnt = 0;
            sda_oe = (ph == 4) && !mem[ptr][7];
        end else if (ph == 4 && cnt > 0 && cnt < 8) begin
            sda_oe = !mem[ptr][7 - cnt];
        end
    endtask

    // One process watches both lines, so every model variable has one writer.
    always @(scl or sda or tick) begin
        if (!scl && scl_was) begin
            scl_low_at = $time;
        end
        if (!sda && sda_was) begin
            sda_low_at = $time;
        end
        if (ph != 0 && !mem[8'h27][7] && ((!scl && $time - scl_low_at > TIMEOUT_NS)
                || (!sda && $time - sda_low_at > TIMEOUT_NS))) begin
            ph = 0;
            sda_oe = 1'h0;
        end else if (scl && scl_was && sda_was && !sda) begin
            ph = 1;
            cnt = 0;
        end else if (scl && scl_was && !sda_was && sda) begin
            ph = 0;
            sda_oe = 1'h0;
        end else if (scl && !scl_was && ph != 0) begin
            if (cnt < 8) begin
                sr = {sr[6:0], sda};
            end else if (ph == 4 && sda) begin
                ph = 0;
            end
            cnt++;
        end else if (!scl && scl_was) begin
            on_scl_fall();
        end
        scl_was = scl;
        sda_was = sda;
    end
endmodule

//--- isra_master_properties.sv
`timescale 1ns/100ps
module isra_master_properties #(
    parameter int QUARTER_CYCLES = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SCL_OUT,
    input wire logic SCL_OE,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic CMD_VALID,
    input wire logic CMD_READY,
    input wire logic RD_VALID,
    input wire logic DONE,
    input wire logic NACK,
    input wire logic ABORT
);
    // Generous enough for a start bit or an ack bit followed by a stop bit.
    localparam int LIM = 12 * QUARTER_CYCLES + 16;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic scl_q;
    int pulses;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_q <= 1'h0;
        end else begin
            scl_q <= SCL_OE;
        end
    end

    // Counts SCL releases in a frame; each byte costs nine.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulses <= 0;
        end else if (CMD_VALID && CMD_READY) begin
            pulses <= 0;
        end else if (scl_q && !SCL_OE) begin
            pulses <= pulses + 1;
        end
    end

    chk_idle_released: assert property (CMD_READY |-> !SCL_OE && !SDA_OE)
        else $error("line driven while idle");
    chk_drive_low_only: assert property (!SCL_OUT && !SDA_OUT)
        else $error("line driven high");
    chk_start_clocks: assert property ($rose(SDA_OE) && !SCL_OE && !scl_q |-> ##[1:LIM] SCL_OE)
        else $error("no clock after start");
    chk_stop_done: assert property ($fell(SDA_OE) && !SCL_OE && !scl_q |-> ##[0:LIM] DONE)
        else $error("no done after stop");
    chk_high_phase: assert property (scl_q && !SCL_OE |-> !SCL_OE [*8])
        else $error("clock high phase too short");
    chk_take_busy: assert property (CMD_VALID && CMD_READY |=> !CMD_READY [*2])
        else $error("ready after take");
    chk_nack_stop: assert property ($rose(NACK) |-> ##[0:LIM] DONE)
        else $error("frame not ended after nack");
    chk_ninth_pulse: assert property (DONE && !ABORT |-> (pulses % 9) inside {2, 3})
        else $error("pulse count not whole bytes");
    chk_read_in_frame: assert property (RD_VALID |-> !CMD_READY)
        else $error("read data outside frame");

    cover property (DONE && NACK);
    cover property (RD_VALID);
    cover property (DONE && !NACK);
    cover property (DONE && ABORT);
endmodule

bind isra_master isra_master_properties #(
    .QUARTER_CYCLES(QUARTER_CYCLES)
) isra_master_properties_inst (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .SCL_OUT(SCL_OUT),
    .SCL_OE(SCL_OE),
    .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE),
    .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY),
    .RD_VALID(RD_VALID),
    .DONE(DONE),
    .NACK(NACK),
    .ABORT(ABORT)
);

//--- test_isra_master.sv
`timescale 1ns/100ps
module test_isra_master;
    localparam logic [1:0] SEL = 2'h2;
    logic sys_clk;
    logic rst_n;
    logic cmd_valid;
    logic cmd_read;
    logic [7:0] cmd_ptr;
    logic [7:0] cmd_count;
    logic [1:0] addr_select;
    logic wr_valid;
    logic [7:0] wr_data;
    logic scl_oe;
    logic sda_oe;
    logic s_oe;
    logic cmd_ready;
    logic wr_taken;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic nack;
    logic abort;
    logic scl_out;
    logic sda_out;
    int fail_count;
    int cmp_count;
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    wire scl = !scl_oe;
    wire sda = !(sda_oe || s_oe);

    isra_master #(.QUARTER_CYCLES(4), .STALL_LIMIT(200)) isra_master_inst (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT(addr_select),
        .CMD_VALID(cmd_valid), .CMD_READ(cmd_read), .CMD_PTR(cmd_ptr),
        .CMD_COUNT(cmd_count), .CMD_READY(cmd_ready), .WR_VALID(wr_valid),
        .WR_DATA(wr_data), .WR_TAKEN(wr_taken), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .DONE(done), .NACK(nack), .ABORT(abort)
    );
    isra_slave_model #(.SEL(SEL)) isra_slave_model_inst (.scl(scl), .sda(sda), .sda_oe(s_oe));

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Runs one command; write bytes come from wq, read bytes land in rq.
    task automatic run_cmd(input logic rd, input logic [7:0] p, input int n, input logic [1:0] s);
        int i;
        int t;
        i = 0;
        t = 0;
        rq.delete();
        @(negedge sys_clk);
        cmd_valid = 1'h1;
        cmd_read = rd;
        cmd_ptr = p;
        cmd_count = 8'(n);
        addr_select = s;
        wr_valid = !rd && n > 0 && wq.size() > 0;
        wr_data = wq[0];
        @(negedge sys_clk);
        cmd_valid = 1'h0;
        while (!done && t < 20000) begin
            if (wr_taken) begin
                i++;
                wr_valid = i < n && i < wq.size();
                if (wr_valid) begin
                    wr_data = wq[i];
                end
            end
            if (rd_valid) begin
                rq.push_back(rd_data);
            end
            @(negedge sys_clk);
            t++;
        end
        wr_valid = 1'h0;
        check({7'h0, t < 20000}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_idle;
        check({5'h0, scl_oe, sda_oe, cmd_ready}, 8'h01);
        check({6'h0, scl_out, sda_out}, 8'h00);
    endtask

    task automatic test_write_burst;
        wq = '{8'hA5, 8'h5A, 8'hC3};
        run_cmd(1'h0, 8'h10, 3, SEL);
        for (int k = 0; k < 3; k++) begin
            check(isra_slave_model_inst.mem[8'h10 + k], wq[k]);
        end
        check(isra_slave_model_inst.ptr, 8'h13);
        check({7'h0, nack}, 8'h00);
    endtask

    task automatic test_ptr_only;
        run_cmd(1'h0, 8'h40, 0, SEL);
        check(isra_slave_model_inst.ptr, 8'h40);
        check(isra_slave_model_inst.mem[8'h40], 8'hBF);
    endtask

    // The pointer moved during the write, so the read reloads it.
    task automatic test_read_back;
        run_cmd(1'h1, 8'h10, 3, SEL);
        check(8'(rq.size()), 8'h03);
        for (int k = 0; k < 3; k++) begin
            check(rq[k], wq[k]);
        end
        check(isra_slave_model_inst.ptr, 8'h13);
        run_cmd(1'h1, 8'h40, 1, SEL);
        check(rq[0], 8'hBF);
    endtask

    task automatic test_group;
        for (int g = 0; g < 2; g++) begin
            wq = '{8'(8'h60 + g)};
            run_cmd(1'h0, 8'(8'h3C + g), 1, SEL);
            for (int k = 0; k < 4; k++) begin
                check(isra_slave_model_inst.mem[2 + 4 * g + k], 8'(8'h60 + g));
            end
        end
    endtask

    // The data source runs dry after one byte; the host must give up and stop.
    task automatic test_stall;
        wq = '{8'h77};
        run_cmd(1'h0, 8'h20, 2, SEL);
        check({7'h0, abort}, 8'h01);
        check(isra_slave_model_inst.mem[8'h20], 8'h77);
        check(isra_slave_model_inst.mem[8'h21], 8'hDE);
    endtask

    task automatic test_addr_select;
        for (int s = 0; s < 4; s++) begin
            run_cmd(1'h0, 8'(8'h50 + s), 0, 2'(s));
            check({7'h0, nack}, {7'h0, 2'(s) != SEL});
        end
        check(isra_slave_model_inst.ptr, 8'h52);
        check({7'h0, abort}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'h0;
        forever begin
            #20 sys_clk = ~sys_clk;
        end
    end

    initial begin
        #2400000;
        fail_count++;
        close_out();
    end

    initial begin
        fail_count = 0;
        cmp_count = 0;
        rst_n = 1'h0;
        cmd_valid = 1'h0;
        cmd_read = 1'h0;
        cmd_ptr = 8'h00;
        cmd_count = 8'h00;
        addr_select = SEL;
        wr_valid = 1'h0;
        wr_data = 8'h00;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'h1;
        test_idle();
        test_write_burst();
        test_ptr_only();
        test_read_back();
        test_group();
        test_stall();
        test_addr_select();
        close_out();
    end
endmodule
